// file: csw_clock_ctrl.sv
`timescale 1ns/1ps
module csw_clock_ctrl #(
   parameter int WAKE_FIX_CYC = csw_pkg::WAKE_FIX_CYC,
   parameter int DIV_W        = csw_pkg::DIV_W
) (
   // Clock and resets
   input  wire logic                      clk_i,
   input  wire logic                      nrst_i,
   input  wire logic                      por_n_i,
   // Non-volatile configuration
   input  wire logic [2:0]                cfg_clk_src_i,
   input  wire logic [csw_pkg::TRIM_W-1:0] factory_trim_i,
   input  wire logic                      rtc_uses_xtal_i,
   // Oscillator sources
   input  wire logic                      wdt_osc_i,
   input  wire logic                      rc_osc_i,
   input  wire logic                      xtal_osc_i,
   input  wire logic                      external_clock_in_pin_i,
   // CPU control
   input  wire logic [DIV_W-1:0]          cpu_clock_divisor_i,
   input  wire logic                      wake_i,
   // Special function register port
   input  wire logic [7:0]                sfr_addr_i,
   input  wire logic                      sfr_wr_i,
   input  wire logic [7:0]                sfr_wdata_i,
   output logic      [7:0]                sfr_rdata_o,
   // Port function of crystal output pin
   input  wire logic                      port_out_i,
   input  wire logic                      port_oe_i,
   // Clocks
   output wire logic                      osc_clock_o,
   output wire logic                      cpu_clock_tick_o,
   output wire logic                      machine_cycle_o,
   output wire logic                      periph_clock_tick_o,
   output wire logic                      cpu_run_o,
   // Oscillator control
   output wire logic [2:0]                osc_mode_o,
   output wire logic [csw_pkg::TRIM_W-1:0] rc_trim_o,
   output wire logic                      rc_osc_clock_o,
   // Crystal output pin
   output wire logic                      crystal_out_clock_pin_o,
   output wire logic                      crystal_out_clock_pin_oe_o
);
   localparam int FIX_W = $clog2(WAKE_FIX_CYC + 1);

   // ----------------------------------------
   // Functions
   // ----------------------------------------
   function automatic logic is_xtal(input csw_pkg::csw_src_e s);
      is_xtal = (s == csw_pkg::SRC_XTAL_LOW) || (s == csw_pkg::SRC_XTAL_MED) ||
                (s == csw_pkg::SRC_XTAL_HIGH);
   endfunction

   function automatic int src_idx(input csw_pkg::csw_src_e s);
      unique case (s)
         csw_pkg::SRC_WDT: src_idx = csw_pkg::IDX_WDT;
         csw_pkg::SRC_RC:  src_idx = csw_pkg::IDX_RC;
         csw_pkg::SRC_EXT: src_idx = csw_pkg::IDX_EXT;
         default:          src_idx = csw_pkg::IDX_XTAL;
      endcase
   endfunction

   // ----------------------------------------
   // Source capture and synchronisers
   // ----------------------------------------
   csw_pkg::csw_src_e         src_reg;
   logic [csw_pkg::N_SRC-1:0] s1_reg;
   logic [csw_pkg::N_SRC-1:0] s2_reg;
   logic [csw_pkg::N_SRC-1:0] s3_reg;
   logic [csw_pkg::N_SRC-1:0] lvl_reg;
   wire  [csw_pkg::N_SRC-1:0] raw_w = {external_clock_in_pin_i, xtal_osc_i, rc_osc_i, wdt_osc_i};
   wire  csw_pkg::csw_src_e   cfg_w = (cfg_clk_src_i > 3'(csw_pkg::SRC_EXT)) ?
                                      csw_pkg::SRC_RC : csw_pkg::csw_src_e'(cfg_clk_src_i);
   wire                       src_xtal_w = is_xtal(src_reg);
   wire  [1:0]                sel_w = 2'(src_idx(src_reg));

   // Configuration is sampled only while reset is held; software cannot alter it
   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         src_reg <= cfg_w;                                        // [R4] [R3]
      end
   end

   // A level counts only once the last two stages agree; one-sample glitches are dropped
   wire  [csw_pkg::N_SRC-1:0] agree_w  = ~(s2_reg ^ s3_reg);
   wire  [csw_pkg::N_SRC-1:0] lvl_next = (agree_w & s3_reg) | (~agree_w & lvl_reg);

   always_ff @(posedge clk_i) begin
      s1_reg  <= raw_w;
      s2_reg  <= s1_reg;
      s3_reg  <= s2_reg;
      lvl_reg <= lvl_next;
   end

   // Edge-based, so an external clock may stop entirely without harm
   wire osc_tick_w = agree_w[sel_w] && s3_reg[sel_w] && !lvl_reg[sel_w]; // [R3] [R15]
   assign osc_clock_o = lvl_reg[sel_w];
   assign osc_mode_o  = src_reg;                                  // [R16]

   // ----------------------------------------
   // Wake-up delay
   // ----------------------------------------
   logic [9:0]       wosc_reg;
   logic [FIX_W-1:0] wfix_reg;
   logic             run_reg;
   wire  [9:0]       wosc_tgt_w = src_xtal_w ? csw_pkg::WAKE_XTAL_CYC
                                             : csw_pkg::WAKE_OTHER_CYC; // [R11] [R12]
   wire              wosc_done_w = (wosc_reg >= wosc_tgt_w);
   wire              wfix_done_w = (wfix_reg >= FIX_W'(WAKE_FIX_CYC));

   always_ff @(posedge clk_i) begin
      if (!nrst_i || wake_i) begin
         wosc_reg <= '0;                                          // [R18]
         wfix_reg <= '0;
         run_reg  <= 1'b0;
      end else begin
         if (osc_tick_w && !wosc_done_w) begin
            wosc_reg <= wosc_reg + 10'h001;                       // [R18]
         end
         if (!wfix_done_w) begin
            wfix_reg <= wfix_reg + FIX_W'(1);
         end
         run_reg <= wosc_done_w && wfix_done_w;                   // [R18] [R11] [R12]
      end
   end
   assign cpu_run_o = run_reg;

   // ----------------------------------------
   // CPU, machine and peripheral clocks
   // ----------------------------------------
   wire  div_tick_w;
   logic phase_reg;
   logic clkout_reg;

   csw_cpu_div #(.DIV_W(DIV_W)) u_div (
      .clk_i      (clk_i),
      .nrst_i     (nrst_i),
      .osc_tick_i (osc_tick_w),
      .divisor_i  (cpu_clock_divisor_i),
      .tick_o     (div_tick_w)
   );

   wire cpu_tick_w = div_tick_w && run_reg;
   assign cpu_clock_tick_o    = cpu_tick_w;
   assign machine_cycle_o     = cpu_tick_w && phase_reg;          // [R1]
   assign periph_clock_tick_o = cpu_tick_w && phase_reg;          // [R2]

   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         phase_reg  <= 1'b0;
         clkout_reg <= 1'b0;
      end else if (cpu_tick_w) begin
         phase_reg  <= !phase_reg;                                // [R1] [R2]
         clkout_reg <= !clkout_reg;                               // [R7]
      end
   end

   // ----------------------------------------
   // Tuning register
   // ----------------------------------------
   logic [7:0] trim_reg;
   wire        trim_wr_w = sfr_wr_i && (sfr_addr_i == csw_pkg::TRIM_ADDR);

   // Only power-on reset reloads it; an ordinary reset keeps the user's tuning
   always_ff @(posedge clk_i) begin
      if (!por_n_i) begin
         trim_reg <= {csw_pkg::TRIM_POR_HI, factory_trim_i};      // [R9]
      end else if (trim_wr_w) begin
         trim_reg <= sfr_wdata_i;                                 // [R10]
      end
   end

   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         sfr_rdata_o <= csw_pkg::SFR_RD_ZERO;
      end else begin
         sfr_rdata_o <= (sfr_addr_i == csw_pkg::TRIM_ADDR) ? trim_reg : csw_pkg::SFR_RD_ZERO;
      end
   end

   assign rc_trim_o      = trim_reg[csw_pkg::TRIM_W-1:0];         // [R10]
   assign rc_osc_clock_o = trim_reg[csw_pkg::TRIM_RC_BIT];

   // ----------------------------------------
   // Crystal output pin
   // ----------------------------------------
   wire clk_out_en_w = trim_reg[csw_pkg::TRIM_EN_BIT];
   wire pin_free_w   = !src_xtal_w && !rtc_uses_xtal_i;           // [R5] [R19]
   wire clkout_w     = pin_free_w && clk_out_en_w;                // [R6]
   wire port_w       = pin_free_w && !clk_out_en_w && (src_reg == csw_pkg::SRC_EXT); // [R14]

   assign crystal_out_clock_pin_oe_o = clkout_w || (port_w && port_oe_i);
   assign crystal_out_clock_pin_o    = clkout_w ? clkout_reg : (port_w && port_out_i); // [R7]

   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   property p_pin_free;
      @(posedge clk_i) disable iff (!nrst_i)
      (src_xtal_w || rtc_uses_xtal_i) |-> !crystal_out_clock_pin_oe_o;
   endproperty
   a_pin_free: assert property (p_pin_free) else $error("pin driven while occupied"); // [R5]

   property p_clkout_en;
      @(posedge clk_i) disable iff (!nrst_i)
      (crystal_out_clock_pin_oe_o && src_reg != csw_pkg::SRC_EXT) |-> clk_out_en_w;
   endproperty
   a_clkout_en: assert property (p_clkout_en) else $error("clock out without enable"); // [R6]

   property p_clkout_rate;
      @(posedge clk_i) disable iff (!nrst_i)
      $changed(clkout_reg) |-> $past(cpu_tick_w);
   endproperty
   a_clkout_rate: assert property (p_clkout_rate) else $error("clock out off rate"); // [R7]

   // Strobe levels at the previous CPU tick; alternation proves the divide by two
   logic last_mc_reg;
   logic last_per_reg;

   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         last_mc_reg  <= 1'b1;
         last_per_reg <= 1'b1;
      end else if (cpu_tick_w) begin
         last_mc_reg  <= machine_cycle_o;
         last_per_reg <= periph_clock_tick_o;
      end
   end

   property p_mc_two;
      @(posedge clk_i) disable iff (!nrst_i)
      (cpu_tick_w || machine_cycle_o) |-> (cpu_tick_w && (machine_cycle_o != last_mc_reg));
   endproperty
   a_mc_two: assert property (p_mc_two) else $error("machine cycle not two clocks"); // [R1]

   property p_pclk;
      @(posedge clk_i) disable iff (!nrst_i)
      (cpu_tick_w || periph_clock_tick_o) |-> (cpu_tick_w && (periph_clock_tick_o != last_per_reg));
   endproperty
   a_pclk: assert property (p_pclk) else $error("peripheral clock too fast"); // [R2]

   property p_div_osc;
      @(posedge clk_i) disable iff (!nrst_i)
      cpu_clock_tick_o |-> (osc_tick_w && run_reg);
   endproperty
   a_div_osc: assert property (p_div_osc) else $error("cpu tick without osc edge"); // [R17]

   property p_wake_hold;
      @(posedge clk_i) disable iff (!nrst_i)
      wake_i |=> !cpu_run_o [*3];
   endproperty
   a_wake_hold: assert property (p_wake_hold) else $error("cpu ran during wake-up"); // [R18]

   property p_run_cause;
      @(posedge clk_i) disable iff (!nrst_i)
      $rose(cpu_run_o) |-> ($past(wosc_reg) >= $past(wosc_tgt_w) && $past(wfix_done_w));
   endproperty
   a_run_cause: assert property (p_run_cause) else $error("early wake release"); // [R11]

   property p_trim_keep;
      @(posedge clk_i) disable iff (!por_n_i)
      !trim_wr_w |=> $stable(trim_reg);
   endproperty
   a_trim_keep: assert property (p_trim_keep) else $error("tuning changed without write"); // [R9]

   property p_trim_wr;
      @(posedge clk_i) disable iff (!por_n_i)
      trim_wr_w |=> (trim_reg == $past(sfr_wdata_i));
   endproperty
   a_trim_wr: assert property (p_trim_wr) else $error("tuning write lost"); // [R10]

endmodule // csw_clock_ctrl

// file: csw_cpu_div.sv
`timescale 1ns/1ps
module csw_cpu_div #(
   parameter int DIV_W = csw_pkg::DIV_W
) (
   // Clock and reset
   input  wire logic             clk_i,
   input  wire logic             nrst_i,
   // Oscillator edge and divisor
   input  wire logic             osc_tick_i,
   input  wire logic [DIV_W-1:0] divisor_i,
   // Divided CPU clock edge
   output wire logic             tick_o
);
   logic [DIV_W:0] cnt_reg;
   logic [DIV_W:0] cnt_next;
   wire  [DIV_W:0] last_w = {divisor_i, 1'b0} - {{DIV_W{1'b0}}, 1'b1};
   wire            bypass_w = (divisor_i == '0);
   // Compare with >= so a divisor lowered mid-count never stalls the CPU clock
   wire            wrap_w = bypass_w || (cnt_reg >= last_w);

   assign tick_o   = osc_tick_i && wrap_w;                        // [R17]
   assign cnt_next = wrap_w ? '0 : cnt_reg + {{DIV_W{1'b0}}, 1'b1};

   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         cnt_reg <= '0;
      end else if (osc_tick_i) begin
         cnt_reg <= cnt_next;                                     // [R17]
      end
   end
endmodule // csw_cpu_div

// file: csw_osc_model.sv
`timescale 1ns/1ps
module csw_osc_model (
   // Speed and run control
   input  wire logic slow_i,
   input  wire logic ext_run_i,
   // Oscillator levels
   output logic      wdt_osc_o,
   output logic      rc_osc_o,
   output logic      xtal_osc_o,
   output logic      ext_clk_o
);
   initial begin
      wdt_osc_o = 1'b0;
      rc_osc_o = 1'b0;
      xtal_osc_o = 1'b0;
      ext_clk_o = 1'b0;
   end
   // Each phase spans three system clocks or more, so the level filter keeps every edge
   always #(slow_i ? 28.0 : 14.0) wdt_osc_o = ~wdt_osc_o;
   always #(slow_i ? 24.0 : 12.0) rc_osc_o = ~rc_osc_o;
   // Slow setting stands in for a low-speed resonator
   always #(slow_i ? 26.0 : 13.0) xtal_osc_o = ~xtal_osc_o;
   // Stopped input holds its level: fully static clock; running rate just under the top rate
   always begin
      #28.0;
      if (ext_run_i) ext_clk_o = ~ext_clk_o;
   end
endmodule // csw_osc_model

// file: csw_pkg.sv
// Functional notes
// R1: Each machine cycle spans exactly two CPU clock periods.
// R2: Peripheral clock runs at half the CPU clock, fed to all peripherals.
// R3: Oscillator clock comes from watchdog, RC, crystal or external clock input.
// R4: Clock source comes from non-volatile configuration, not a software register.
// R5: Clock output allowed only without crystal source and without crystal-clocked RTC.
// R6: Clock output pin driven only while clock output enable bit is set.
// R7: Clock output runs at half the CPU clock frequency.
// R8: Software should clear clock output enable before Idle if unused.
// R9: Six-bit tuning field loads factory value on power-on reset only.
// R10: Software may overwrite the tuning field any time to retune RC oscillator.
// R11: Crystal modes hold CPU clock 992 oscillator cycles plus 60-100 us. The code runs both counts at once and releases after the longer one.
// R12: RC, watchdog or external source hold CPU clock 224 cycles plus 60-100 us. The code runs both counts at once and releases after the longer one.
// R13: System must enable reset input pin above 12 MHz oscillator clock.
// R14: External clock mode lets crystal output pin be port pin or clock output.
// R15: External clock input works fully static up to 18 MHz.
// R16: Distinct low-speed crystal mode for 20 kHz to 100 kHz resonators.
// R17: Oscillator clock divided by programmable divisor up to 510, changeable anytime.
// R18: Wake-up counter on oscillator clock restarts on wake, releases after both delays.
// R19: Enable bit has no effect while crystal or crystal RTC occupies the pin.
package csw_pkg;

   // ----------------------------------------
   // Register map
   // ----------------------------------------
   localparam logic [7:0] TRIM_ADDR     = 8'h96;
   localparam int         TRIM_RC_BIT   = 7;
   localparam int         TRIM_EN_BIT   = 6;
   localparam int         TRIM_W        = 6;
   localparam logic [1:0] TRIM_POR_HI   = 2'h0;
   localparam logic [7:0] SFR_RD_ZERO   = 8'h00;

   // ----------------------------------------
   // Clock sources
   // ----------------------------------------
   typedef enum logic [2:0] {
      SRC_XTAL_LOW  = 3'h0,
      SRC_XTAL_MED  = 3'h1,
      SRC_XTAL_HIGH = 3'h2,
      SRC_RC        = 3'h3,
      SRC_WDT       = 3'h4,
      SRC_EXT       = 3'h5
   } csw_src_e;

   localparam int N_SRC    = 4;
   localparam int IDX_WDT  = 0;
   localparam int IDX_RC   = 1;
   localparam int IDX_XTAL = 2;
   localparam int IDX_EXT  = 3;

   // ----------------------------------------
   // Timing
   // ----------------------------------------
   localparam int         CLK_MHZ        = 250;
   localparam int         WAKE_US_MIN    = 60;
   localparam int         WAKE_FIX_CYC   = WAKE_US_MIN * CLK_MHZ;
   localparam logic [9:0] WAKE_XTAL_CYC  = 10'h3E0;
   localparam logic [9:0] WAKE_OTHER_CYC = 10'h0E0;
   localparam int         DIV_W          = 8;

endpackage

// file: tb_csw_clock_ctrl.sv
`timescale 1ns/1ps
module tb_csw_clock_ctrl;
   // ------------------------
   // Stimulus and counters
   // ------------------------
   logic       clk_i = 1'b0, nrst_i = 1'b0, por_n_i = 1'b0, rtc = 1'b0, wake = 1'b0, wr = 1'b0;
   logic       pout = 1'b0, poe = 1'b0, slow = 1'b0, ext_run = 1'b1;
   logic [2:0] cfg = 3'h3, cur = 3'h3, mode;
   logic [5:0] fac = 6'h00, trim_o;
   logic [7:0] div = 8'h00, addr = 8'h00, wdata = 8'h00, rdata, v;
   logic       wdt, rc, xtal, ext, sel, osc_o, tick, mach, per, run, rc_msb, pin, pin_oe;
   int         errors = 0, compares = 0, cyc = 0, osc_n = 0, tick_n = 0, mach_n = 0, per_n = 0, tog_n = 0;
   int         oso_n = 0;
   int         m_trim, w, e, d;

   always #2 clk_i = ~clk_i;
   // Codes above the external source fall back to the RC oscillator
   assign sel = (cur <= 3'h2) ? xtal : (cur == 3'h4) ? wdt : (cur == 3'h5) ? ext : rc;
   always @(posedge sel) osc_n++;
   always @(posedge osc_o) oso_n++;
   always @(pin) tog_n++;
   always @(posedge clk_i) begin
      cyc++;
      tick_n += 32'(tick);
      mach_n += 32'(mach);
      per_n += 32'(per);
      if (cyc == 60000) begin
         errors++;
         close_out();
      end
   end

   csw_osc_model u_osc (.slow_i(slow), .ext_run_i(ext_run), .wdt_osc_o(wdt), .rc_osc_o(rc),
      .xtal_osc_o(xtal), .ext_clk_o(ext));

   csw_clock_ctrl #(.WAKE_FIX_CYC(20)) u_dut (.clk_i(clk_i), .nrst_i(nrst_i), .por_n_i(por_n_i),
      .cfg_clk_src_i(cfg), .factory_trim_i(fac), .rtc_uses_xtal_i(rtc), .wdt_osc_i(wdt),
      .rc_osc_i(rc), .xtal_osc_i(xtal), .external_clock_in_pin_i(ext), .cpu_clock_divisor_i(div),
      .wake_i(wake), .sfr_addr_i(addr), .sfr_wr_i(wr), .sfr_wdata_i(wdata), .sfr_rdata_o(rdata),
      .port_out_i(pout), .port_oe_i(poe), .osc_clock_o(osc_o), .cpu_clock_tick_o(tick),
      .machine_cycle_o(mach), .periph_clock_tick_o(per), .cpu_run_o(run), .osc_mode_o(mode),
      .rc_trim_o(trim_o), .rc_osc_clock_o(rc_msb), .crystal_out_clock_pin_o(pin),
      .crystal_out_clock_pin_oe_o(pin_oe));

   // ------------------------
   // Tasks
   // ------------------------
   task automatic close_out();
      if (errors == 0 && compares > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] lo, input logic [31:0] hi, input logic [31:0] got);
      compares++;
      if ($isunknown(got) || ((lo === hi) ? (got !== lo) : !(got >= lo && got <= hi))) begin
         errors++;
         $display("wrong value %s expected %0d..%0d seen %0d", nm, lo, hi, got);
      end
   endtask

   task automatic wr_sfr(input logic [7:0] a, input logic [7:0] dv);
      addr = a;
      wdata = dv;
      wr = 1'b1;
      @(negedge clk_i);
      wr = 1'b0;
      if (a == 8'h96) m_trim = 32'(dv);
   endtask

   task automatic rd_sfr(input logic [7:0] a);
      addr = a;
      repeat (2) @(negedge clk_i);
      v = rdata;
   endtask

   // Reset or wake, then count selected oscillator edges until the CPU clock is let go
   task automatic start(input logic [2:0] s, input logic p, input logic wk);
      if (wk) begin
         wake = 1'b1;
         @(negedge clk_i);
         wake = 1'b0;
         osc_n = 0;
         @(negedge clk_i);
         chk("run_after_wake", 0, 0, 32'(run));
      end else begin
         cfg = s;
         cur = s;
         slow = (s == 3'h0);
         por_n_i = ~p;
         nrst_i = 1'b0;
         repeat (5) @(negedge clk_i);
         chk("run_in_reset", 0, 0, 32'(run));
         nrst_i = 1'b1;
         por_n_i = 1'b1;
         osc_n = 0;
      end
      e = (s <= 3'h2) ? 992 : 224;
      for (int n = 0; n < 20000 && run !== 1'b1; n++) @(negedge clk_i);
      chk("wake_edges", 32'(e - 1), 32'(e + 3), 32'(osc_n));
   endtask

   // ------------------------
   // Sequence
   // ------------------------
   initial begin
      void'($urandom(80));
      fac = 6'($urandom);
      start(3'h7, 1'b1, 1'b0);
      chk("mode_illegal", 3, 3, 32'(mode));
      rd_sfr(8'h96);
      chk("trim_por", 32'(fac), 32'(fac), 32'(v));
      w = $urandom;
      wr_sfr(8'h96, w[7:0]);
      rd_sfr(8'h96);
      chk("trim_read", m_trim, m_trim, 32'(v));
      chk("rc_trim", m_trim % 64, m_trim % 64, 32'(trim_o));
      chk("rc_clk_bit", m_trim / 128, m_trim / 128, 32'(rc_msb));
      wr_sfr(8'h95, 8'hFF);
      rd_sfr(8'h95);
      chk("unmapped", 0, 0, 32'(v));
      for (int s = 0; s < 6; s++) begin
         fac = ~fac;
         start(3'(s), 1'b0, 1'b0);
         chk("mode", 32'(s), 32'(s), 32'(mode));
         rd_sfr(8'h96);
         chk("trim_no_por", m_trim, m_trim, 32'(v));
         wr_sfr(8'h96, 8'(8'h40 | (m_trim % 64)));
         chk("pin_oe_free", 32'(s > 2), 32'(s > 2), 32'(pin_oe));
         rtc = 1'b1;
         @(negedge clk_i);
         chk("pin_oe_rtc", 0, 0, 32'(pin_oe));
         rtc = 1'b0;
         wr_sfr(8'h96, 8'(m_trim % 64));
         pout = w[s];
         poe = 1'b1;
         @(negedge clk_i);
         chk("pin_oe_off", 32'(s == 5), 32'(s == 5), 32'(pin_oe));
         if (s == 5) chk("pin_port", 32'(pout), 32'(pout), 32'(pin));
         poe = 1'b0;
      end
      cfg = 3'h0;
      repeat (3) @(negedge clk_i);
      chk("mode_live_cfg", 5, 5, 32'(mode));
      wr_sfr(8'h96, 8'h40);
      for (int k = 0; k < 3; k++) begin
         d = (k == 0) ? 0 : (k == 1) ? 1 : 2 + $urandom % 4;
         div = 8'(d);
         repeat (4) @(negedge clk_i);
         e = (d == 0) ? 12 : 24 * d;
         osc_n = 0;
         tick_n = 0;
         mach_n = 0;
         per_n = 0;
         tog_n = 0;
         oso_n = 0;
         for (int n = 0; n < 3000 && osc_n < e; n++) @(negedge clk_i);
         repeat (6) @(negedge clk_i);
         chk("osc_clock_edges", 32'(osc_n - 1), 32'(osc_n + 1), 32'(oso_n));
         chk("cpu_ticks", 10, 14, 32'(tick_n));
         chk("periph_ticks", 32'(tick_n / 2 - 1), 32'(tick_n / 2 + 1), 32'(per_n));
         chk("machine_cycles", 32'(tick_n / 2 - 1), 32'(tick_n / 2 + 1), 32'(mach_n));
         chk("clock_out_toggles", 32'(tick_n - 1), 32'(tick_n + 1), 32'(tog_n));
      end
      ext_run = 1'b0;
      repeat (10) @(negedge clk_i);
      tick_n = 0;
      repeat (40) @(negedge clk_i);
      chk("ticks_static", 0, 0, 32'(tick_n));
      ext_run = 1'b1;
      start(3'h5, 1'b0, 1'b1);
      close_out();
   end
endmodule // tb_csw_clock_ctrl
